//--- rtl/qres_pkg.sv
package qres_pkg;
    localparam int PORT_W = 4;
    localparam int QOS_N = 8;
    localparam int WM_W = 16;
    localparam int WM_DEPTH = 1024;
    localparam int IDX_W = 10;
    localparam int RED_N = 16;
    localparam int TMR_W = 8;

    // Byte addresses on the register bus
    localparam logic [15:0] A_WM_BASE = 16'h0000;
    localparam logic [15:0] A_STAT_BASE = 16'h1000;
    localparam logic [15:0] A_FREE_MEM = 16'h2000;
    localparam logic [15:0] A_FREE_REF = 16'h2004;
    localparam logic [15:0] A_EGR_DISCARD = 16'h2008;
    localparam logic [15:0] A_IGR_NOSHARE = 16'h200C;
    localparam logic [15:0] A_EGR_NOSHARE = 16'h2010;
    localparam logic [15:0] A_DRAIN_DIS = 16'h2014;
    localparam logic [15:0] A_HOLD_EN = 16'h2018;
    localparam logic [15:0] A_REPEAT_EN = 16'h201C;
    localparam logic [15:0] A_ENERGY_EN = 16'h2020;
    localparam logic [15:0] A_STATUS = 16'h2024;
    localparam logic [15:0] A_GLOBAL_LVL = 16'h2028;
    localparam logic [15:0] A_TAIL_LVL = 16'h202C;
    localparam logic [15:0] A_PAUSE_LVL = 16'h2030;
    localparam logic [15:0] A_EEE_TIMERS = 16'h2034;
    localparam logic [15:0] A_EEE_THRES = 16'h2038;
    localparam logic [15:0] A_URGENT_MASK = 16'h203C;
    localparam logic [15:0] A_RED_BASE = 16'h2040;

    // Watermark index layout: {group, offset}
    localparam logic [1:0] GRP_BUF_I = 2'h0;
    localparam logic [1:0] GRP_REF_I = 2'h1;
    localparam logic [1:0] GRP_BUF_E = 2'h2;
    localparam logic [1:0] GRP_REF_E = 2'h3;
    localparam logic [7:0] OFS_QRSV = 8'h00;
    localparam logic [7:0] OFS_PRSV = 8'hE0;
    localparam logic [7:0] OFS_PRIO = 8'hF0;
    localparam logic [7:0] OFS_COL = 8'hF8;

    // Values after reset
    localparam logic [WM_W-1:0] WM_RST = 16'hFFFF;
    localparam logic [15:0] LFSR_RST = 16'hACE1;
    localparam logic [TMR_W-1:0] HOLDOFF_RST = 8'h0A;
    localparam logic [TMR_W-1:0] AGE_RST = 8'h14;
    localparam logic [TMR_W-1:0] WAKE_RST = 8'h05;
    localparam logic [15:0] LVL_RST = 16'hFFFF;

    // Timer base: one tick per microsecond
    localparam int CLK_NS = 100;
    localparam int US_NS = 1000;
    localparam int TICK_CYC = (US_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [1:0] {
        ST_ACTIVE = 2'b00,
        ST_SLEEP = 2'b01,
        ST_LPI = 2'b10,
        ST_WAKE = 2'b11
    } eee_state_t;

    typedef enum logic [1:0] {
        AREA_QUEUE = 2'b00,
        AREA_PORT = 2'b01,
        AREA_SHARED = 2'b10
    } area_t;

    typedef struct packed {
        logic vld;
        logic [PORT_W-1:0] igr;
        logic [PORT_W-1:0] egr;
        logic [2:0] qos;
        logic dp;
    } xfer_req_t;

    typedef struct packed {
        logic vld;
        logic admit;
        logic drop;
        logic hold;
        area_t area;
    } xfer_res_t;
endpackage

//--- rtl/queue_resource_pause_lpi.sv
`timescale 1ns/1ps
// How it works
// R1: All watermarks sit in one watermark_config_array of 1024 words.
// R2: consumption_statistics shows present and peak use; reading restarts peak tracking.
// R3: free_memory_count and free_reference_count are readable.
// R4: Congested transfer is dropped if either end is in drop mode, else held.
// R5: ingress_shared_block_mask makes every sharing watermark count as exceeded.
// R6: egress_shared_block_mask makes every sharing watermark count as exceeded.
// R7: early_discard_profile gives discard chance rising linearly from low to high.
// R8: queue_drain_disable stops both transmission and dequeuing of a port.
// R9: hold_back_enable selects holding back and allows pause requests for a port.
// R10: global_congestion_flag sets above set level, clears below clear level.
// R11: Pause asserts only with global flag set and port use above start.
// R12: Pause deasserts when port use falls below stop level.
// R13: Frame written while both tail discard levels are exceeded is discarded.
// R14: Repeater transmits head-of-line frames without dequeuing them.
// R15: Reservation compared with use before the frame is added.
// R16: Per-port state machine reports active, sleep, idle, wake to the PCS.
// R17: Low power idle only runs where energy_save_enable is set.
// R18: Queues empty for idle_before_sleep_time moves an active port to sleep.
// R19: Enqueue while asleep starts the sleep_aging_time timer.
// R20: Wake on urgent queue, frame or byte threshold, or aging expiry.
// R21: After waking, data is withheld until resync_delay_time has elapsed.
// R22: port_low_power_status is set from sleep through wake-up inclusive.
// R23: Copy made only when memory and reference checks both pass.
// R24: Frame draws from queue reserve, then port reserve, then shared area.
// R25: Pause request is a per-port level updated every cycle.
module queue_resource_pause_lpi #(
    parameter int NPORTS = 12,
    parameter logic [15:0] MEM_TOTAL = 16'h1C00
) (
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [15:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire qres_pkg::xfer_req_t XFER_REQ,
    output qres_pkg::xfer_res_t XFER_RES,
    input wire logic USE_VLD,
    input wire logic [qres_pkg::IDX_W-1:0] USE_IDX,
    input wire logic [qres_pkg::WM_W-1:0] USE_VAL,
    input wire logic [15:0] FREE_MEM,
    input wire logic [15:0] FREE_REF,
    input wire logic [NPORTS-1:0] WR_ACTIVE,
    output logic [NPORTS-1:0] TAIL_DISCARD,
    input wire logic [NPORTS-1:0][7:0] EGR_NONEMPTY,
    input wire logic [NPORTS-1:0][15:0] EGR_FRAMES,
    input wire logic [NPORTS-1:0][15:0] EGR_BYTES,
    input wire logic [NPORTS-1:0] ENQ,
    output logic [NPORTS-1:0] PAUSE_REQ,
    output logic [NPORTS-1:0] TX_ALLOW,
    output logic [NPORTS-1:0] DEQ_ALLOW,
    output logic [NPORTS-1:0] REPEAT,
    output qres_pkg::eee_state_t [NPORTS-1:0] LPI_STATE
);
    import qres_pkg::*;

    if (NPORTS < 1 || NPORTS > 16) begin : g_chk
        $error("NPORTS must be 1 to 16");
    end

    typedef struct packed {
        logic [31:0] prdata;
        logic pslverr;
        logic [15:0] free_mem;
        logic [15:0] free_ref;
        logic [NPORTS-1:0] egr_drop;
        logic [NPORTS-1:0] ig_mask;
        logic [NPORTS-1:0] eg_mask;
        logic [NPORTS-1:0] drain_dis;
        logic [NPORTS-1:0] hold_en;
        logic [NPORTS-1:0] repeat_en;
        logic [NPORTS-1:0] eee_en;
        logic [15:0] gset;
        logic [15:0] gclr;
        logic [15:0] ptail;
        logic [15:0] gtail;
        logic [15:0] pstart;
        logic [15:0] pstop;
        logic [TMR_W-1:0] t_hold;
        logic [TMR_W-1:0] t_age;
        logic [TMR_W-1:0] t_wake;
        logic [15:0] thr_frames;
        logic [15:0] thr_bytes;
        logic [7:0] fast_mask;
        logic gflag;
        logic [NPORTS-1:0] pause;
        logic [NPORTS-1:0] tail;
        logic [15:0] lfsr;
        xfer_res_t res;
        logic [3:0] tick_cnt;
        logic tick;
        eee_state_t [NPORTS-1:0] st;
        logic [NPORTS-1:0][TMR_W-1:0] cnt;
        logic [NPORTS-1:0] age_run;
    } state_t;

    state_t s_q, s_d;
    logic [WM_W-1:0] wm_mem [0:WM_DEPTH-1];
    logic [WM_W-1:0] cur_mem [0:WM_DEPTH-1];
    logic [WM_W-1:0] peak_mem [0:WM_DEPTH-1];
    logic [31:0] red_mem [0:RED_N-1];
    logic setup, access, wr_wm, wr_red, clr_stat;
    logic [IDX_W-1:0] aidx;
    logic [15:0] total;

    function automatic logic [IDX_W-1:0] widx(input logic [1:0] g, input logic [7:0] ofs);
        return {g, ofs};
    endfunction

    // Use is taken before the frame is added, so a small reserve admits one frame
    function automatic logic exc(input logic [IDX_W-1:0] i);
        return cur_mem[i] >= wm_mem[i]; // see R15
    endfunction

    function automatic logic rsv_ok(input logic [1:0] g, input logic [PORT_W-1:0] p,
                                    input logic [2:0] q);
        return !exc(widx(g, OFS_QRSV + {1'b0, p, q})) || !exc(widx(g, OFS_PRSV + 8'(p)));
    endfunction

    function automatic logic shr_ok(input logic [1:0] gi, input logic [1:0] ge,
                                    input logic [2:0] q, input logic d);
        return !(exc(widx(ge, OFS_PRIO + 8'(q))) || exc(widx(ge, OFS_COL + 8'(d)))
            || exc(widx(gi, OFS_PRIO + 8'(q))) || exc(widx(gi, OFS_COL + 8'(d))));
    endfunction

    function automatic logic red_hit(input logic [31:0] prof, input logic [15:0] use_v,
                                     input logic [15:0] rnd);
        logic [31:0] lhs;
        logic [31:0] rhs;
        lhs = {16'(use_v - prof[15:0]), 16'h0000};
        rhs = rnd * (prof[31:16] - prof[15:0]);
        if (use_v > prof[31:16]) begin
            return 1'b1;
        end
        if (use_v <= prof[15:0]) begin
            return 1'b0;
        end
        return lhs > rhs; // see R7
    endfunction

    function automatic logic [15:0] port_use(input int p);
        return cur_mem[widx(GRP_BUF_I, OFS_PRSV + 8'(p))];
    endfunction

    assign setup = PSEL && !PENABLE;
    assign access = PSEL && PENABLE;
    assign aidx = PADDR[IDX_W+1:2];
    assign wr_wm = access && PWRITE && PADDR[15:12] == A_WM_BASE[15:12];
    assign wr_red = access && PWRITE && PADDR[15:6] == A_RED_BASE[15:6];
    assign clr_stat = access && !PWRITE && PADDR[15:12] == A_STAT_BASE[15:12]; // see R2
    assign total = MEM_TOTAL - s_q.free_mem;

    always_comb begin
        logic mem_ok;
        logic ref_ok;
        logic sh_blk;
        logic dmode;
        logic pass;
        logic wake;
        logic nonempty;
        mem_ok = 1'b0;
        ref_ok = 1'b0;
        sh_blk = 1'b0;
        dmode = 1'b0;
        pass = 1'b0;
        wake = 1'b0;
        nonempty = 1'b0;
        s_d = s_q;
        // Register read data is latched in the setup cycle, so reads never wait
        if (setup) begin
            s_d.pslverr = 1'b0;
            s_d.prdata = 32'h0000_0000;
            if (PADDR[15:12] == A_WM_BASE[15:12]) begin
                s_d.prdata = 32'(wm_mem[aidx]); // see R1
            end else if (PADDR[15:12] == A_STAT_BASE[15:12]) begin
                s_d.prdata = {peak_mem[aidx], cur_mem[aidx]}; // see R2
            end else if (PADDR[15:6] == A_RED_BASE[15:6]) begin
                s_d.prdata = red_mem[PADDR[5:2]];
            end else begin
                case (PADDR)
                    A_FREE_MEM: s_d.prdata = 32'(s_q.free_mem); // see R3
                    A_FREE_REF: s_d.prdata = 32'(s_q.free_ref); // see R3
                    A_EGR_DISCARD: s_d.prdata = 32'(s_q.egr_drop);
                    A_IGR_NOSHARE: s_d.prdata = 32'(s_q.ig_mask);
                    A_EGR_NOSHARE: s_d.prdata = 32'(s_q.eg_mask);
                    A_DRAIN_DIS: s_d.prdata = 32'(s_q.drain_dis);
                    A_HOLD_EN: s_d.prdata = 32'(s_q.hold_en);
                    A_REPEAT_EN: s_d.prdata = 32'(s_q.repeat_en);
                    A_ENERGY_EN: s_d.prdata = 32'(s_q.eee_en);
                    A_GLOBAL_LVL: s_d.prdata = {s_q.gclr, s_q.gset};
                    A_TAIL_LVL: s_d.prdata = {s_q.gtail, s_q.ptail};
                    A_PAUSE_LVL: s_d.prdata = {s_q.pstop, s_q.pstart};
                    A_EEE_TIMERS: s_d.prdata = {8'h00, s_q.t_wake, s_q.t_age, s_q.t_hold};
                    A_EEE_THRES: s_d.prdata = {s_q.thr_bytes, s_q.thr_frames};
                    A_URGENT_MASK: s_d.prdata = 32'(s_q.fast_mask);
                    A_STATUS: begin
                        for (int p = 0; p < NPORTS; p++) begin
                            s_d.prdata[p] = s_q.st[p] != ST_ACTIVE; // see R22
                            s_d.prdata[16 + p] = s_q.pause[p];
                        end
                        s_d.prdata[31] = s_q.gflag;
                    end
                    default: s_d.pslverr = 1'b1;
                endcase
            end
        end
        if (access && PWRITE) begin
            case (PADDR)
                A_EGR_DISCARD: s_d.egr_drop = PWDATA[NPORTS-1:0];
                A_IGR_NOSHARE: s_d.ig_mask = PWDATA[NPORTS-1:0];
                A_EGR_NOSHARE: s_d.eg_mask = PWDATA[NPORTS-1:0];
                A_DRAIN_DIS: s_d.drain_dis = PWDATA[NPORTS-1:0];
                A_HOLD_EN: s_d.hold_en = PWDATA[NPORTS-1:0];
                A_REPEAT_EN: s_d.repeat_en = PWDATA[NPORTS-1:0];
                A_ENERGY_EN: s_d.eee_en = PWDATA[NPORTS-1:0];
                A_GLOBAL_LVL: {s_d.gclr, s_d.gset} = PWDATA;
                A_TAIL_LVL: {s_d.gtail, s_d.ptail} = PWDATA;
                A_PAUSE_LVL: {s_d.pstop, s_d.pstart} = PWDATA;
                A_EEE_TIMERS: {s_d.t_wake, s_d.t_age, s_d.t_hold} = PWDATA[23:0];
                A_EEE_THRES: {s_d.thr_bytes, s_d.thr_frames} = PWDATA;
                A_URGENT_MASK: s_d.fast_mask = PWDATA[7:0];
                default: s_d.fast_mask = s_q.fast_mask;
            endcase
        end
        s_d.free_mem = FREE_MEM; // see R3
        s_d.free_ref = FREE_REF;
        s_d.lfsr = {s_q.lfsr[14:0], s_q.lfsr[15] ^ s_q.lfsr[13] ^ s_q.lfsr[12] ^ s_q.lfsr[10]};

        // Admission of one ingress to egress copy per cycle
        sh_blk = s_q.ig_mask[XFER_REQ.igr] || s_q.eg_mask[XFER_REQ.egr]; // see R5 R6
        mem_ok = rsv_ok(GRP_BUF_I, XFER_REQ.igr, XFER_REQ.qos)
            || rsv_ok(GRP_BUF_E, XFER_REQ.egr, XFER_REQ.qos)
            || (!sh_blk && shr_ok(GRP_BUF_I, GRP_BUF_E, XFER_REQ.qos, XFER_REQ.dp)
                && !red_hit(red_mem[{XFER_REQ.qos, XFER_REQ.dp}],
                    cur_mem[widx(GRP_BUF_E, OFS_PRIO + 8'(XFER_REQ.qos))], s_q.lfsr));
        ref_ok = rsv_ok(GRP_REF_I, XFER_REQ.igr, XFER_REQ.qos)
            || rsv_ok(GRP_REF_E, XFER_REQ.egr, XFER_REQ.qos)
            || (!sh_blk && shr_ok(GRP_REF_I, GRP_REF_E, XFER_REQ.qos, XFER_REQ.dp));
        pass = mem_ok && ref_ok; // see R23
        // Ingress ports without hold-back are in drop mode
        dmode = !s_q.hold_en[XFER_REQ.igr] || s_q.egr_drop[XFER_REQ.egr]; // see R4 R9
        s_d.res.vld = XFER_REQ.vld;
        s_d.res.admit = XFER_REQ.vld && pass;
        s_d.res.drop = XFER_REQ.vld && !pass && dmode; // see R4
        s_d.res.hold = XFER_REQ.vld && !pass && !dmode;
        if (!exc(widx(GRP_BUF_E, OFS_QRSV + {1'b0, XFER_REQ.egr, XFER_REQ.qos}))) begin
            s_d.res.area = AREA_QUEUE; // see R24
        end else if (!exc(widx(GRP_BUF_E, OFS_PRSV + 8'(XFER_REQ.egr)))) begin
            s_d.res.area = AREA_PORT;
        end else begin
            s_d.res.area = AREA_SHARED;
        end

        // Global hysteresis flag, then per-port pause levels
        if (total > s_q.gset) begin
            s_d.gflag = 1'b1; // see R10
        end else if (total < s_q.gclr) begin
            s_d.gflag = 1'b0;
        end
        for (int p = 0; p < NPORTS; p++) begin
            if (!s_q.hold_en[p]) begin
                s_d.pause[p] = 1'b0; // see R9
            end else if (s_q.gflag && port_use(p) > s_q.pstart) begin
                s_d.pause[p] = 1'b1; // see R11 R25
            end else if (port_use(p) < s_q.pstop) begin
                s_d.pause[p] = 1'b0; // see R12
            end
            // Discard stays marked until the frame write ends
            if (!WR_ACTIVE[p]) begin
                s_d.tail[p] = 1'b0;
            end else if (port_use(p) > s_q.ptail && total > s_q.gtail) begin
                s_d.tail[p] = 1'b1; // see R13
            end
        end

        s_d.tick = s_q.tick_cnt == 4'(TICK_CYC - 1);
        s_d.tick_cnt = s_d.tick ? 4'h0 : s_q.tick_cnt + 4'h1;
        for (int p = 0; p < NPORTS; p++) begin
            nonempty = |EGR_NONEMPTY[p];
            wake = |(EGR_NONEMPTY[p] & s_q.fast_mask) || EGR_FRAMES[p] > s_q.thr_frames
                || EGR_BYTES[p] > s_q.thr_bytes || !s_q.eee_en[p]
                || (s_q.age_run[p] && s_q.tick && s_q.cnt[p] >= s_q.t_age); // see R20
            case (s_q.st[p])
                ST_ACTIVE: begin
                    if (!s_q.eee_en[p] || nonempty) begin
                        s_d.cnt[p] = '0; // see R17
                    end else if (s_q.tick) begin
                        if (s_q.cnt[p] >= s_q.t_hold) begin
                            s_d.st[p] = ST_SLEEP; // see R18
                            s_d.cnt[p] = '0;
                            s_d.age_run[p] = 1'b0;
                        end else begin
                            s_d.cnt[p] = s_q.cnt[p] + 1'b1;
                        end
                    end
                end
                ST_SLEEP: s_d.st[p] = ST_LPI; // see R16
                ST_LPI: begin
                    if (wake) begin
                        s_d.st[p] = ST_WAKE;
                        s_d.cnt[p] = '0;
                    end else if ((ENQ[p] || nonempty) && !s_q.age_run[p]) begin
                        s_d.age_run[p] = 1'b1; // see R19
                        s_d.cnt[p] = '0;
                    end else if (s_q.age_run[p] && s_q.tick) begin
                        s_d.cnt[p] = s_q.cnt[p] + 1'b1;
                    end
                end
                ST_WAKE: begin
                    if (s_q.tick) begin
                        if (s_q.cnt[p] >= s_q.t_wake) begin
                            s_d.st[p] = ST_ACTIVE; // see R21
                            s_d.cnt[p] = '0;
                        end else begin
                            s_d.cnt[p] = s_q.cnt[p] + 1'b1;
                        end
                    end
                end
                default: s_d.st[p] = ST_ACTIVE;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            s_q <= '0;
            s_q.gset <= LVL_RST;
            s_q.gclr <= LVL_RST;
            s_q.ptail <= LVL_RST;
            s_q.gtail <= LVL_RST;
            s_q.pstart <= LVL_RST;
            s_q.pstop <= LVL_RST;
            s_q.thr_frames <= LVL_RST;
            s_q.thr_bytes <= LVL_RST;
            s_q.t_hold <= HOLDOFF_RST;
            s_q.t_age <= AGE_RST;
            s_q.t_wake <= WAKE_RST;
            s_q.lfsr <= LFSR_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // A usage update in the same cycle as a read wins over the peak restart
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            for (int i = 0; i < WM_DEPTH; i++) begin
                wm_mem[i] <= WM_RST;
                cur_mem[i] <= '0;
                peak_mem[i] <= '0;
            end
            for (int i = 0; i < RED_N; i++) begin
                red_mem[i] <= 32'hFFFF_FFFF;
            end
        end else begin
            if (wr_wm) begin
                wm_mem[aidx] <= PWDATA[WM_W-1:0]; // see R1
            end
            if (wr_red) begin
                red_mem[PADDR[5:2]] <= PWDATA;
            end
            if (clr_stat) begin
                peak_mem[aidx] <= cur_mem[aidx]; // see R2
            end
            if (USE_VLD) begin
                cur_mem[USE_IDX] <= USE_VAL;
                if ((clr_stat && aidx == USE_IDX) || USE_VAL > peak_mem[USE_IDX]) begin
                    peak_mem[USE_IDX] <= USE_VAL;
                end
            end
        end
    end

    assign PRDATA = s_q.prdata;
    assign PSLVERR = s_q.pslverr && access;
    assign PREADY = access;
    assign XFER_RES = s_q.res;
    assign PAUSE_REQ = s_q.pause;
    assign TAIL_DISCARD = s_q.tail;
    assign LPI_STATE = s_q.st;
    always_comb begin
        for (int p = 0; p < NPORTS; p++) begin
            TX_ALLOW[p] = !s_q.drain_dis[p] && s_q.st[p] == ST_ACTIVE; // see R8 R21
            DEQ_ALLOW[p] = !s_q.drain_dis[p] && !s_q.repeat_en[p]; // see R8 R14
            REPEAT[p] = s_q.repeat_en[p] && !s_q.drain_dis[p]; // see R14
        end
    end

    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RESET);

    sequence enter_sleep0;
        s_q.st[0] == ST_ACTIVE ##1 s_q.st[0] == ST_SLEEP;
    endsequence
    wm_store_a: assert property (wr_wm |=> wm_mem[$past(aidx)] == $past(PWDATA[WM_W-1:0])) // see R1
        else $error("watermark write lost");
    peak_clear_a: assert property (clr_stat && !USE_VLD |=> peak_mem[$past(aidx)] == $past(cur_mem[aidx])) // see R2
        else $error("peak not restarted by read");
    free_count_a: assert property (setup && PADDR == A_FREE_MEM |=> PRDATA[15:0] == $past(FREE_MEM, 2)) // see R3
        else $error("free count read wrong");
    drop_mode_a: assert property (XFER_REQ.vld && s_q.egr_drop[XFER_REQ.egr] |=> !XFER_RES.hold) // see R4
        else $error("hold despite egress drop mode");
    global_flag_a: assert property (total > s_q.gset |=> s_q.gflag) // see R10
        else $error("global flag not set");
    pause_cause_a: assert property (|(PAUSE_REQ & ~$past(PAUSE_REQ)) |-> $past(s_q.gflag)) // see R11
        else $error("pause rose without global flag");
    drain_block_a: assert property (!(|(s_q.drain_dis & (TX_ALLOW | DEQ_ALLOW)))) // see R8
        else $error("drained port still sends");
    sleep_cause_a: assert property (enter_sleep0 |-> $past(s_q.eee_en[0] && EGR_NONEMPTY[0] == 8'h00)) // see R17 R18
        else $error("sleep entered with data or disabled");
    urgent_wake_a: assert property (s_q.st[0] == ST_LPI && |(EGR_NONEMPTY[0] & s_q.fast_mask) |=> s_q.st[0] == ST_WAKE) // see R20
        else $error("urgent queue did not wake port");
    tail_mark_a: assert property (WR_ACTIVE[0] && port_use(0) > s_q.ptail && total > s_q.gtail |=> TAIL_DISCARD[0] [*1] ##0 WR_ACTIVE[0] || TAIL_DISCARD[0]) // see R13
        else $error("tail discard missed");
endmodule

//--- test/qres_queue_model.sv
`timescale 1ns/1ps
module qres_queue_model #(
    parameter int NPORTS = 12
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [NPORTS-1:0] add,
    input wire logic [NPORTS-1:0] tx_ok,
    input wire logic [NPORTS-1:0] deq_ok,
    output logic [NPORTS-1:0][7:0] busy,
    output logic [NPORTS-1:0][15:0] frames,
    output logic [NPORTS-1:0][15:0] bytes,
    output logic [NPORTS-1:0] enq
);
    // A frame leaves only when both sending and dequeuing are allowed
    always_ff @(posedge clk) begin
        for (int i = 0; i < NPORTS; i++) begin
            enq[i] <= add[i] && !rst;
            if (rst) frames[i] <= 16'h0;
            else if (add[i]) frames[i] <= frames[i] + 16'h1;
            else if (tx_ok[i] && deq_ok[i] && frames[i] != 16'h0) frames[i] <= frames[i] - 16'h1;
        end
    end
    always_comb begin
        for (int i = 0; i < NPORTS; i++) begin
            busy[i] = {7'h0, frames[i] != 16'h0};
            bytes[i] = {frames[i][9:0], 6'h0};
        end
    end
endmodule

//--- test/queue_resource_pause_lpi_bench.sv
`timescale 1ns/1ps
module queue_resource_pause_lpi_bench;
    import qres_pkg::*;
    localparam int NP = 12;
    logic CLK_SYS, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, USE_VLD, err;
    logic [15:0] PADDR, FREE_MEM, FREE_REF, v;
    logic [31:0] PWDATA, PRDATA, rd;
    logic [IDX_W-1:0] USE_IDX, ix;
    logic [WM_W-1:0] USE_VAL;
    logic [NP-1:0] WR_ACTIVE, TAIL_DISCARD, ENQ, PAUSE_REQ, TX_ALLOW, DEQ_ALLOW, REPEAT, add;
    logic [NP-1:0][7:0] EGR_NONEMPTY;
    logic [NP-1:0][15:0] EGR_FRAMES, EGR_BYTES;
    xfer_req_t XFER_REQ;
    xfer_res_t XFER_RES;
    eee_state_t [NP-1:0] LPI_STATE;
    int failures = 0, n_tests = 0, cyc = 0, seed = 32'h93B1, p, q;
    queue_resource_pause_lpi #(.NPORTS(NP)) queue_resource_pause_lpi_i (.CLK_SYS, .RESET,
        .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .XFER_REQ,
        .XFER_RES, .USE_VLD, .USE_IDX, .USE_VAL, .FREE_MEM, .FREE_REF, .WR_ACTIVE,
        .TAIL_DISCARD, .EGR_NONEMPTY, .EGR_FRAMES, .EGR_BYTES, .ENQ, .PAUSE_REQ,
        .TX_ALLOW, .DEQ_ALLOW, .REPEAT, .LPI_STATE);
    qres_queue_model #(.NPORTS(NP)) qres_queue_model_i (.clk(CLK_SYS), .rst(RESET), .add,
        .tx_ok(TX_ALLOW), .deq_ok(DEQ_ALLOW), .busy(EGR_NONEMPTY), .frames(EGR_FRAMES),
        .bytes(EGR_BYTES), .enq(ENQ));
    function automatic logic [9:0] prsv(int port);
        return {GRP_BUF_I, OFS_PRSV + 8'(port)};
    endfunction
    function automatic logic [31:0] bit_of(int port);
        return 32'h1 << port;
    endfunction
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Request held until PREADY is seen high at a rising edge
    task automatic apb(logic w, logic [15:0] a, logic [31:0] d);
        PSEL <= 1'h1;
        PENABLE <= 1'h0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK_SYS);
        PENABLE <= 1'h1;
        do @(posedge CLK_SYS); while (PREADY !== 1'h1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
        @(posedge CLK_SYS);
    endtask
    task automatic use_upd(logic [9:0] i, logic [15:0] val);
        USE_VLD <= 1'h1;
        USE_IDX <= i;
        USE_VAL <= val;
        @(posedge CLK_SYS);
        USE_VLD <= 1'h0;
        repeat (3) @(posedge CLK_SYS);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        CLK_SYS = 1'h0;
        forever #50 CLK_SYS = ~CLK_SYS;
    end
    always @(posedge CLK_SYS) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            wrap_up();
        end
    end
    initial begin
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA, USE_VLD, USE_IDX, USE_VAL} = '0;
        {XFER_REQ, WR_ACTIVE, add} = '0;
        RESET = 1'h1;
        FREE_MEM = 16'h1C00;
        FREE_REF = 16'h0777;
        repeat (16) @(posedge CLK_SYS);
        RESET <= 1'h0;
        @(posedge CLK_SYS);
        p = {$random(seed)} % NP;
        q = (p + 1) % NP;
        repeat (4) begin
            ix = $random(seed);
            v = $random(seed);
            apb(1'h0, 16'({ix, 2'h0}), 32'h0); chk(rd, 32'h0000FFFF);
            apb(1'h1, 16'({ix, 2'h0}), {16'h0, v});
            apb(1'h0, 16'({ix, 2'h0}), 32'h0); chk(rd, {16'h0, v});
        end
        apb(1'h0, A_FREE_MEM, 32'h0); chk(rd, 32'h1C00);
        apb(1'h0, A_FREE_REF, 32'h0); chk(rd, 32'h0777);
        apb(1'h1, 16'h3000, 32'h1234); chk({err, rd[30:0]}, 32'h80000000);
        $display("test registers done");
        v = {1'h1, v[14:0]};
        use_upd(prsv(p), v);
        use_upd(prsv(p), 16'h0010);
        apb(1'h0, A_STAT_BASE | 16'({prsv(p), 2'h0}), 32'h0); chk(rd, {v, 16'h0010});
        apb(1'h0, A_STAT_BASE | 16'({prsv(p), 2'h0}), 32'h0); chk(rd, 32'h00100010);
        $display("test statistics done");
        apb(1'h1, A_GLOBAL_LVL, 32'h08001000);
        apb(1'h1, A_PAUSE_LVL, 32'h00800100);
        apb(1'h1, A_HOLD_EN, bit_of(p));
        use_upd(prsv(p), 16'h0200);
        use_upd(prsv(q), 16'h0200); chk(PAUSE_REQ, 32'h0);
        FREE_MEM <= 16'h0000;
        repeat (4) @(posedge CLK_SYS);
        chk(PAUSE_REQ, bit_of(p));
        use_upd(prsv(p), 16'h00C0); chk(PAUSE_REQ, bit_of(p));
        use_upd(prsv(p), 16'h0040); chk(PAUSE_REQ, 32'h0);
        apb(1'h0, A_STATUS, 32'h0); chk(32'(rd[31]), 32'h1);
        apb(1'h1, A_TAIL_LVL, 32'h01000100);
        WR_ACTIVE <= '1;
        repeat (3) @(posedge CLK_SYS);
        chk(TAIL_DISCARD, bit_of(q));
        WR_ACTIVE <= '0;
        repeat (3) @(posedge CLK_SYS);
        chk(TAIL_DISCARD, 32'h0);
        $display("test pause and tail done");
        XFER_REQ <= '{vld: 1'h1, igr: 4'(p), egr: 4'(q), qos: 3'($random(seed)), dp: 1'h0};
        @(posedge CLK_SYS);
        XFER_REQ <= '0;
        @(negedge CLK_SYS);
        chk({XFER_RES.vld, XFER_RES.admit, XFER_RES.drop}, 32'h6);
        @(posedge CLK_SYS);
        apb(1'h1, A_DRAIN_DIS, bit_of(p));
        add <= NP'(bit_of(p));
        @(posedge CLK_SYS);
        add <= '0;
        repeat (3) @(posedge CLK_SYS);
        chk(EGR_FRAMES[p], 32'h1);
        chk({TX_ALLOW[p], DEQ_ALLOW[p]}, 32'h0);
        apb(1'h1, A_DRAIN_DIS, 32'h0);
        apb(1'h1, A_REPEAT_EN, bit_of(q)); chk(EGR_FRAMES[p], 32'h0);
        chk({REPEAT[q], DEQ_ALLOW[q]}, 32'h2);
        $display("test transfer and drain done");
        apb(1'h1, A_ENERGY_EN, bit_of(p));
        repeat (120) @(posedge CLK_SYS);
        chk(LPI_STATE[p], ST_LPI);
        chk(LPI_STATE[q], ST_ACTIVE);
        apb(1'h0, A_STATUS, 32'h0); chk(32'(rd[NP-1:0]), bit_of(p));
        add <= NP'(bit_of(p));
        @(posedge CLK_SYS);
        add <= '0;
        repeat (150) @(posedge CLK_SYS);
        chk(LPI_STATE[p], ST_LPI);
        repeat (75) @(posedge CLK_SYS);
        chk({LPI_STATE[p], TX_ALLOW[p]}, {ST_WAKE, 1'h0});
        repeat (75) @(posedge CLK_SYS);
        chk({LPI_STATE[p], EGR_FRAMES[p]}, {ST_ACTIVE, 16'h0});
        $display("test energy save done");
        wrap_up();
    end
endmodule
